// ==== dprs_dev_model.sv ====
// behavioural model of one device port and its flags
`timescale 1ns/100ps
module dprs_dev_model
  import dprs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire dprs_pins_t pins_in,
  input wire logic [7:0] far_req_n_in,
  output logic [7:0] dq_out = 8'h00
);
  // ****************
  // state
  // ****************
  logic [7:0] mem [4096];
  logic [7:0] hreq = 8'h00;
  logic [7:0] hown = 8'hFF;
  logic [7:0] fown = 8'h00;
  logic [7:0] lat = 8'h00;
  dprs_pins_t p = '1;
  wire wr_end = pins_in.write_n && !p.write_n;
  always @(posedge clk_sys_in) begin
    p <= pins_in;
    if (wr_end && !p.mem_select_n) begin
      mem[p.addr] <= p.dq_out;
    end else if (wr_end && !p.flag_select_n) begin
      hreq[p.addr[2:0]] <= p.dq_out[0];
    end
    for (int i = 0; i < 8; i++) begin
      if (hown[i] && hreq[i]) begin
        hown[i] <= 1'b0;
      end else if (fown[i] && far_req_n_in[i]) begin
        fown[i] <= 1'b0;
      end else if (!hown[i] && !fown[i]) begin
        hown[i] <= !hreq[i];
        fown[i] <= hreq[i] && !far_req_n_in[i];
      end
    end
    if (!pins_in.flag_select_n && !pins_in.out_en_n &&
        (p.flag_select_n || p.out_en_n)) begin
      lat <= {8{!hown[pins_in.addr[2:0]]}};
    end
    if (!pins_in.out_en_n && pins_in.write_n && !pins_in.mem_select_n) begin
      dq_out <= mem[pins_in.addr];
    end else if (!p.out_en_n && !p.flag_select_n) begin
      dq_out <= lat;
    end else begin
      dq_out <= ~dq_out;
    end
  end
endmodule : dprs_dev_model

// ==== dprs_host.sv ====
// host controller driving one port of the dual-port memory with flags
//
// Functional notes
// - address changes only while write strobe or memory select high
// - memory access: mem select low, flag high; flag access reversed
// - memory select stays high through flag write then flag read
// - flags active low; write zero requests, same side's one releases
// - request by writing zero then reading back; zero means granted
// - after failure keep polling or write one to withdraw
// - at start write one to every flag to clear requests
`timescale 1ns/100ps
module dprs_host
  import dprs_pkg::*;
#(
  parameter int ADDR_W = DPRS_ADDR_W,
  parameter int DATA_W = DPRS_DATA_W
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  input wire dprs_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output dprs_rsp_t rsp_out,
  output logic mem_select_n_out,
  output logic flag_select_n_out,
  output logic write_n_out,
  output logic out_en_n_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic [DATA_W-1:0] dq_in
);
  // ***********************************************
  // parameter check
  // ***********************************************
  if (ADDR_W != DPRS_ADDR_W || DATA_W != DPRS_DATA_W) begin : g_bad_width
    $error("port widths must match the package");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WRITE,
    ST_RECOVER,
    ST_READ,
    ST_GAP,
    ST_DONE
  } dprs_state_t;

  typedef struct packed {
    dprs_state_t state;
    logic [DPRS_CNT_W-1:0] cnt;
    dprs_req_t cur;
    logic [DPRS_FLAG_W:0] init_idx;
    logic rd_after_wr;
    dprs_pins_t pins;
    logic ready;
    logic rsp_valid;
    dprs_rsp_t rsp;
  } dprs_host_st_t;

  dprs_host_st_t st;
  dprs_host_st_t next_st;
  logic [DATA_W-1:0] dq_sync;

  dprs_sync #(
    .WIDTH(DATA_W)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .d_in(dq_in),
    .q_out(dq_sync)
  );

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic is_flag_op(input dprs_op_t op);
    return op != DPRS_OP_MEM_RD && op != DPRS_OP_MEM_WR;
  endfunction : is_flag_op

  function automatic logic is_write_op(input dprs_op_t op);
    return op != DPRS_OP_MEM_RD && op != DPRS_OP_FLAG_RD;
  endfunction : is_write_op

  function automatic logic [DPRS_CNT_W-1:0] cyc(input int n);
    return DPRS_CNT_W'(n - 1);
  endfunction : cyc

  // ***********************************************
  // sequencer
  // ***********************************************
  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    case (st.state)
      ST_IDLE: begin
        next_st.ready = 1'b1;
        if (req_valid_in && st.ready) begin
          next_st.ready = 1'b0;
          next_st.cur = req_in;
          next_st.init_idx = '0;
          // acquire is a write of zero then a read back
          next_st.rd_after_wr = req_in.op == DPRS_OP_FLAG_ACQ;
          // address set while both strobes still high
          next_st.pins.addr = req_in.addr;
          if (is_flag_op(req_in.op)) begin
            // only the low three bits matter for a flag
            next_st.pins.addr = {{(ADDR_W-DPRS_FLAG_W){1'b0}},
                                 req_in.addr[DPRS_FLAG_W-1:0]};
          end
          if (req_in.op == DPRS_OP_INIT) begin
            next_st.pins.addr = '0;
          end
          next_st.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // exactly one select low for the access
        next_st.pins.mem_select_n = is_flag_op(st.cur.op);
        next_st.pins.flag_select_n = !is_flag_op(st.cur.op);
        if (is_write_op(st.cur.op)) begin
          // write overlap of strobe and select
          next_st.pins.write_n = 1'b0;
          next_st.pins.out_en_n = 1'b1;
          next_st.pins.dq_oe = 1'b1;
          // flag value rides on bit zero
          case (st.cur.op)
            DPRS_OP_FLAG_ACQ: next_st.pins.dq_out = 8'h00;
            // same write withdraws a failed request
            DPRS_OP_FLAG_REL: next_st.pins.dq_out = 8'hFF;
            DPRS_OP_INIT: next_st.pins.dq_out = 8'hFF;
            default: next_st.pins.dq_out = st.cur.wdata;
          endcase
          next_st.cnt = cyc(DPRS_T_WP_CYC);
          next_st.state = ST_WRITE;
        end else begin
          next_st.pins.out_en_n = 1'b0;
          next_st.cnt = cyc(DPRS_T_RD_CYC) + 5'h02;
          next_st.state = ST_READ;
        end
      end
      ST_WRITE: begin
        if (st.cnt == '0) begin
          // write strobe rises first; outputs never enabled
          next_st.pins.write_n = 1'b1;
          next_st.state = ST_RECOVER;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      ST_RECOVER: begin
        next_st.pins.dq_oe = 1'b0;
        if (st.rd_after_wr) begin
          // memory select stays high, flag select stays low
          next_st.pins.out_en_n = 1'b1;
          next_st.cnt = cyc(DPRS_T_SWR_CYC);
          next_st.state = ST_GAP;
        end else begin
          next_st.pins.mem_select_n = 1'b1;
          next_st.pins.flag_select_n = 1'b1;
          next_st.state = ST_DONE;
        end
      end
      ST_GAP: begin
        if (st.cnt == '0) begin
          // output enable edge latches a fresh flag value
          next_st.pins.out_en_n = 1'b0;
          next_st.cnt = cyc(DPRS_T_RD_CYC) + 5'h02;
          next_st.state = ST_READ;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      ST_READ: begin
        if (st.cnt == '0) begin
          next_st.rsp.rdata = dq_sync;
          // flag reads back on bit zero like all bits
          // zero read back means the token is ours
          next_st.rsp.granted = is_flag_op(st.cur.op) && !dq_sync[0];
          // drop both enables so the next poll re-latches
          next_st.pins.out_en_n = 1'b1;
          next_st.pins.mem_select_n = 1'b1;
          next_st.pins.flag_select_n = 1'b1;
          next_st.state = ST_DONE;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      ST_DONE: begin
        // init walks all eight flags writing one
        if (st.cur.op == DPRS_OP_INIT &&
            st.init_idx[DPRS_FLAG_W-1:0] !=
            DPRS_FLAG_W'(DPRS_NUM_FLAGS - 1)) begin
          next_st.init_idx = st.init_idx + 4'h1;
          next_st.pins.addr = {{(ADDR_W-DPRS_FLAG_W){1'b0}},
                               next_st.init_idx[DPRS_FLAG_W-1:0]};
          next_st.state = ST_SETUP;
        end else begin
          // both selects high: port in standby
          next_st.rsp_valid = 1'b1;
          if (st.cur.op == DPRS_OP_INIT || (is_write_op(st.cur.op) &&
              st.cur.op != DPRS_OP_FLAG_ACQ)) begin
            next_st.rsp = '0;
          end
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    if (srst_in) begin
      next_st = '0;
      next_st.state = ST_IDLE;
      next_st.cnt = DPRS_CNT_RST;
      next_st.pins.mem_select_n = 1'b1;
      next_st.pins.flag_select_n = 1'b1;
      next_st.pins.write_n = 1'b1;
      next_st.pins.out_en_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st <= next_st;
  end

  assign req_ready_out = st.ready;
  assign rsp_valid_out = st.rsp_valid;
  assign rsp_out = st.rsp;
  assign mem_select_n_out = st.pins.mem_select_n;
  assign flag_select_n_out = st.pins.flag_select_n;
  assign write_n_out = st.pins.write_n;
  assign out_en_n_out = st.pins.out_en_n;
  assign addr_out = st.pins.addr;
  assign dq_out = st.pins.dq_out;
  assign dq_oe_out = st.pins.dq_oe;
endmodule : dprs_host

// ==== dprs_host_monitor.sv ====
// checker for the host strobe sequencing
`timescale 1ns/100ps
module dprs_host_monitor
  import dprs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic mem_select_n_out,
  input wire logic flag_select_n_out,
  input wire logic write_n_out,
  input wire logic out_en_n_out,
  input wire logic [DPRS_ADDR_W-1:0] addr_out,
  input wire logic dq_oe_out
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  sequence s_wr_hold;
    !write_n_out [*8];
  endsequence
  property p_sel_excl;
    !(!mem_select_n_out && !flag_select_n_out);
  endproperty
  property p_addr_hold;
    $changed(addr_out) |-> (write_n_out || mem_select_n_out) &&
      ($past(write_n_out) || $past(mem_select_n_out));
  endproperty
  property p_wr_sel;
    !write_n_out |-> (!mem_select_n_out || !flag_select_n_out);
  endproperty
  property p_wr_width;
    $fell(write_n_out) |-> s_wr_hold;
  endproperty
  property p_flag_addr;
    !flag_select_n_out |-> addr_out[11:3] == 9'h000;
  endproperty
  property p_mem_drive;
    (!mem_select_n_out && !write_n_out) |-> dq_oe_out;
  endproperty
  property p_oe_off;
    dq_oe_out |-> out_en_n_out;
  endproperty
  property p_rd_strobe;
    !out_en_n_out |-> write_n_out && !(mem_select_n_out && flag_select_n_out);
  endproperty
  // read must end so a later poll re-latches the flag
  sequence s_oe_back;
    ##[1:16] out_en_n_out;
  endsequence
  property p_oe_release;
    $fell(out_en_n_out) |-> s_oe_back;
  endproperty
  property p_standby;
    (mem_select_n_out && flag_select_n_out) |->
      (write_n_out && out_en_n_out && !dq_oe_out);
  endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("both selects low");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in write");
  a_wr_sel: assert property (p_wr_sel)
    else $error("write without select");
  a_wr_width: assert property (p_wr_width)
    else $error("write pulse short");
  a_flag_addr: assert property (p_flag_addr)
    else $error("flag address upper bits set");
  a_mem_drive: assert property (p_mem_drive)
    else $error("write data not driven");
  a_oe_off: assert property (p_oe_off)
    else $error("bus fight");
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("bad read strobe");
  a_oe_release: assert property (p_oe_release)
    else $error("output enable held too long");
  a_standby: assert property (p_standby)
    else $error("strobe active in standby");
endmodule : dprs_host_monitor

bind dprs_host dprs_host_monitor mon_u (
  .clk_sys_in, .srst_in, .mem_select_n_out, .flag_select_n_out,
  .write_n_out, .out_en_n_out, .addr_out, .dq_oe_out
);

// ==== dprs_host_tb.sv ====
// self-checking bench for the host controller
`timescale 1ns/100ps
module dprs_host_tb;
  import dprs_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid_in = 1'b0;
  dprs_req_t req_in = '0;
  logic req_ready_out, rsp_valid_out;
  dprs_rsp_t rsp_out;
  wire dprs_pins_t pins;
  logic [7:0] dq_in;
  logic [7:0] far_req_n = 8'hFF;
  // entry: check granted, rdata, granted
  logic [9:0] exp_q[$];
  logic [9:0] e;
  logic [11:0] a;
  logic [26:0] rst_seen;
  logic [15:0] lfsr = 16'h4EC7;
  int bad_count = 0;
  int comparisons = 0;
  int sent = 0;
  int got = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  dprs_host dut_u (
    .clk_sys_in, .srst_in, .req_valid_in, .req_in, .req_ready_out,
    .rsp_valid_out, .rsp_out, .mem_select_n_out(pins.mem_select_n),
    .flag_select_n_out(pins.flag_select_n), .write_n_out(pins.write_n),
    .out_en_n_out(pins.out_en_n), .addr_out(pins.addr),
    .dq_out(pins.dq_out), .dq_oe_out(pins.dq_oe), .dq_in
  );
  dprs_dev_model dev_u (
    .clk_sys_in, .pins_in(pins), .far_req_n_in(far_req_n), .dq_out(dq_in)
  );
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic do_op(input dprs_op_t op, input logic [11:0] ad,
                       input logic [7:0] wd, input logic [9:0] ex);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_in <= '{op: op, addr: ad, wdata: wd};
    exp_q.push_back(ex);
    sent++;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 400);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    while (got < sent && n < 400) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("ERROR rsp_valid_out exp 1 seen 0 op %0d", op);
      print_verdict();
    end
  endtask : do_op
  always @(negedge clk_sys_in) begin
    if (rsp_valid_out === 1'b1) begin
      got++;
      comparisons++;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("ERROR rsp_valid_out exp 0 seen 1");
      end else begin
        e = exp_q.pop_front();
        if (rsp_out.rdata !== e[8:1] ||
            (e[9] && rsp_out.granted !== e[0])) begin
          bad_count++;
          $display("ERROR rsp_out exp %h seen %h", e[8:0], rsp_out);
        end
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    do_op(DPRS_OP_FLAG_RD, 12'h002, 8'h00, 10'h201);
    do_op(DPRS_OP_INIT, 12'h000, 8'h00, 10'h200);
    do_op(DPRS_OP_FLAG_RD, 12'h002, 8'h00, 10'h3FE);
    $display("test init done");
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 12'hFFF : lfsr[11:0];
      do_op(DPRS_OP_MEM_WR, a, lfsr[15:8], 10'h200);
      do_op(DPRS_OP_MEM_RD, a, 8'h00, {1'b1, lfsr[15:8], 1'b0});
    end
    $display("test memory done");
    // mid-run reset while idle; flag state lives in the device
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    comparisons++;
    rst_seen = {req_ready_out, pins.write_n, pins.out_en_n,
                pins.mem_select_n, pins.flag_select_n, pins.dq_oe,
                pins.addr, rsp_out};
    if (rst_seen !== 27'h3C00000) begin
      bad_count++;
      $display("ERROR reset state exp 3C00000 seen %h", rst_seen);
    end
    @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    $display("test reset done");
    // far side owns flag 5, host request must wait
    far_req_n <= 8'hDF;
    do_op(DPRS_OP_FLAG_ACQ, 12'h005, 8'h00, 10'h3FE);
    far_req_n <= 8'hFF;
    do_op(DPRS_OP_FLAG_RD, 12'h005, 8'h00, 10'h201);
    far_req_n <= 8'hDF;
    do_op(DPRS_OP_FLAG_REL, 12'h005, 8'h00, 10'h200);
    do_op(DPRS_OP_FLAG_RD, 12'h005, 8'h00, 10'h3FE);
    far_req_n <= 8'hFF;
    do_op(DPRS_OP_FLAG_ACQ, 12'hFF5, 8'h00, 10'h201);
    do_op(DPRS_OP_FLAG_REL, 12'h005, 8'h00, 10'h200);
    do_op(DPRS_OP_FLAG_RD, 12'h005, 8'h00, 10'h3FE);
    $display("test flags done");
    print_verdict();
  end
endmodule : dprs_host_tb

// ==== dprs_pkg.sv ====
// shared constants and types for the dual-port memory host controller
package dprs_pkg;
  localparam int DPRS_ADDR_W = 12;
  localparam int DPRS_DATA_W = 8;
  localparam int DPRS_FLAG_W = 3;
  localparam int DPRS_NUM_FLAGS = 8;
  localparam int DPRS_CLK_NS = 8;
  // write pulse and select to end of write, worst speed grade
  localparam int DPRS_T_WP_NS = 60;
  localparam int DPRS_T_WP_CYC = (DPRS_T_WP_NS + DPRS_CLK_NS - 1) / DPRS_CLK_NS;
  // read access, covered with a larger figure than the write pulse to stay safe
  localparam int DPRS_T_RD_NS = 70;
  localparam int DPRS_T_RD_CYC = (DPRS_T_RD_NS + DPRS_CLK_NS - 1) / DPRS_CLK_NS;
  // flag write to read time
  localparam int DPRS_T_SWR_NS = 10;
  localparam int DPRS_T_SWR_CYC =
    (DPRS_T_SWR_NS + DPRS_CLK_NS - 1) / DPRS_CLK_NS;
  localparam int DPRS_CNT_W = 5;
  localparam logic [DPRS_CNT_W-1:0] DPRS_CNT_RST = 5'h00;

  typedef enum logic [2:0] {
    DPRS_OP_MEM_RD,
    DPRS_OP_MEM_WR,
    DPRS_OP_FLAG_ACQ,
    DPRS_OP_FLAG_REL,
    DPRS_OP_FLAG_RD,
    DPRS_OP_INIT
  } dprs_op_t;

  typedef struct packed {
    dprs_op_t op;
    logic [DPRS_ADDR_W-1:0] addr;
    logic [DPRS_DATA_W-1:0] wdata;
  } dprs_req_t;

  typedef struct packed {
    logic [DPRS_DATA_W-1:0] rdata;
    logic granted;
  } dprs_rsp_t;

  typedef struct packed {
    logic mem_select_n;
    logic flag_select_n;
    logic write_n;
    logic out_en_n;
    logic [DPRS_ADDR_W-1:0] addr;
    logic [DPRS_DATA_W-1:0] dq_out;
    logic dq_oe;
  } dprs_pins_t;
endpackage : dprs_pkg

// ==== dprs_sync.sv ====
// two-stage synchroniser for the data bus coming back from the device
`timescale 1ns/100ps
module dprs_sync
  import dprs_pkg::*;
#(
  parameter int WIDTH = DPRS_DATA_W
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dprs_sync_st_t;
  dprs_sync_st_t st;
  dprs_sync_st_t next_st;

  if (WIDTH < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  always_comb begin
    next_st = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    if (srst_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st <= next_st;
  end

  assign q_out = st.s2;
endmodule : dprs_sync
